// ==== hw/conv_regs_pkg.sv ====
package conv_regs_pkg;

	// Register indices on the serial target interface
	localparam logic [7:0] ADDR_VOUT_TWO = 8'h02;
	localparam logic [7:0] ADDR_CONTROL = 8'h03;
	localparam logic [7:0] ADDR_STATUS = 8'h05;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// Reset values
	localparam logic [7:0] VOUT_TWO_RST = 8'h64;
	localparam logic [7:0] CONTROL_RST = 8'h6F;
	localparam logic [7:0] STATUS_RST = 8'h00;

	// Control field positions
	localparam int CTL_RESET_BIT = 7;
	localparam int CTL_FORCED_PULSE_WIDTH_OPERATION_TRANS_BIT = 6;
	localparam int CTL_FORCED_PULSE_WIDTH_OPERATION_BIT = 4;
	localparam int CTL_DISCH_BIT = 3;
	localparam int CTL_RETRY_BIT = 2;

	// Status field positions
	localparam int STS_THERM_BIT = 4;
	localparam int STS_RETRY_BIT = 3;
	localparam int STS_UNDERVOLTAGE_LOCKOUT_FLAG_BIT = 0;

	// Voltage mapping: base and step in microvolts
	localparam int VOUT_BASE_UV = 400000;
	localparam int VOUT_STEP_UV = 5000;

	// Ramp step times and clock period in picoseconds
	localparam int CLK_PERIOD_PS = 10000;
	localparam int RAMP_STEP0_PS = 250000;
	localparam int RAMP_STEP1_PS = 500000;
	localparam int RAMP_STEP2_PS = 1000000;
	localparam int RAMP_STEP3_PS = 5000000;
	localparam int RAMP_CYC0 = RAMP_STEP0_PS / CLK_PERIOD_PS;
	localparam int RAMP_CYC1 = RAMP_STEP1_PS / CLK_PERIOD_PS;
	localparam int RAMP_CYC2 = RAMP_STEP2_PS / CLK_PERIOD_PS;
	localparam int RAMP_CYC3 = RAMP_STEP3_PS / CLK_PERIOD_PS;

	// Register access request from the serial engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_t;

	// Converter configuration outputs
	typedef struct packed {
		logic forced_pulse_width_operation;
		logic discharge_en;
		logic retry_protect;
		logic [1:0] ramp_sel;
	} conv_cfg_t;

	// Ramp engine states
	typedef enum logic [1:0] {
		RAMP_IDLE = 2'b00,
		RAMP_WAIT = 2'b01,
		RAMP_STEP = 2'b11
	} ramp_state_t;

endpackage

// ==== hw/conv_regs.sv ====
`timescale 1ns/1ps
// Contract
// - Voltage code maps 400 to 1675 mV linearly
// - Voltage code resets to 0x64
// - Address 0x02 is voltage code, read/write
// - Address 0x03 is control, write only
// - Control bit 7 resets all registers
// - Bit 6 forces PWM during transitions
// - Bit 4 selects power save or PWM
// - Bit 3 enables output discharge, reset one
// - Bit 2 selects retry or latching protection
// - Bits 1:0 set ramp step time
// - Address 0x05 is status, read only
// - Status bit 4 flags thermal warning
// - Status bit 3 flags retry entered once
// - Status bit 0 flags undervoltage lockout
// - Status latched until reset or read
// - New written target is adopted
// - Unmapped addresses read 0x00
// - Write commits at acknowledge clock fall
// - Enable falling edge resets registers
module conv_regs
	import conv_regs_pkg::*;
#(
	parameter int RAMP_CYC_SLOW = RAMP_CYC3
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Serial engine side, same clock domain
	input wire reg_req_t req,
	input wire logic ack_fall,
	output logic [7:0] rd_data_q,
	// Device pins and monitors
	input wire logic enable_pin,
	input wire logic therm_warn_in,
	input wire logic retry_event_in,
	input wire logic undervoltage_in,
	// Converter controls
	output conv_cfg_t cfg_q,
	output logic [7:0] vout_code_two_q,
	output logic [7:0] vout_active_q,
	output logic pwm_force_q,
	output logic restart_q
);

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [1:0] en_sync_q;
	logic [1:0] th_sync_q;
	logic [1:0] rt_sync_q;
	logic [1:0] uv_sync_q;
	logic en_prev_q;
	logic [7:0] ctl_q;
	logic [7:0] status_q;
	logic soft_reset;
	logic en_fall;
	logic clear_all;
	logic wr_commit;
	logic ramp_tick;
	logic [12:0] ramp_cnt_q;
	ramp_state_t ramp_state_q;

	// Pins come from outside the clock domain
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			en_sync_q <= 2'h0;
			th_sync_q <= 2'h0;
			rt_sync_q <= 2'h0;
			uv_sync_q <= 2'h0;
		end else begin
			en_sync_q <= {en_sync_q[0], enable_pin};
			th_sync_q <= {th_sync_q[0], therm_warn_in};
			rt_sync_q <= {rt_sync_q[0], retry_event_in};
			uv_sync_q <= {uv_sync_q[0], undervoltage_in};
		end
	end

	// Enable history for edge detection on the synced level
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			en_prev_q <= 1'b0;
		end else begin
			en_prev_q <= en_sync_q[1];
		end
	end

	////////////////////////////////////////////////////////////////
	// Reset sources and write strobe
	assign en_fall = en_prev_q & ~en_sync_q[1];
	// Data is latched at the acknowledge clock fall, not on request
	assign wr_commit = req.wr & ack_fall;
	assign soft_reset = wr_commit && req.addr == ADDR_CONTROL &&
		req.data[CTL_RESET_BIT];
	assign clear_all = soft_reset | en_fall;

	////////////////////////////////////////////////////////////////
	// Voltage target register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			vout_code_two_q <= VOUT_TWO_RST;
		end else if (clear_all) begin
			vout_code_two_q <= VOUT_TWO_RST;
		end else if (wr_commit && req.addr == ADDR_VOUT_TWO) begin
			vout_code_two_q <= req.data;
		end
	end

	// Control register; reset bit itself never stored, reads back zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctl_q <= CONTROL_RST;
		end else if (clear_all) begin
			ctl_q <= CONTROL_RST;
		end else if (wr_commit && req.addr == ADDR_CONTROL) begin
			ctl_q <= {1'b0, req.data[6:0]};
		end
	end

	// Decoded configuration straight from flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= '0;
			restart_q <= 1'b0;
		end else begin
			cfg_q.forced_pulse_width_operation <= ctl_q[CTL_FORCED_PULSE_WIDTH_OPERATION_BIT];
			cfg_q.discharge_en <= ctl_q[CTL_DISCH_BIT];
			cfg_q.retry_protect <= ctl_q[CTL_RETRY_BIT];
			cfg_q.ramp_sel <= ctl_q[1:0];
			restart_q <= soft_reset;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status flags; an event in the read cycle survives the clear
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_q <= STATUS_RST;
		end else begin
			if (clear_all || (req.rd && req.addr == ADDR_STATUS)) begin
				status_q <= STATUS_RST;
			end
			if (th_sync_q[1]) begin
				status_q[STS_THERM_BIT] <= 1'b1;
			end
			if (rt_sync_q[1]) begin
				status_q[STS_RETRY_BIT] <= 1'b1;
			end
			if (uv_sync_q[1]) begin
				status_q[STS_UNDERVOLTAGE_LOCKOUT_FLAG_BIT] <= 1'b1;
			end
		end
	end

	// Read mux; control is write only so it reads as unmapped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_data_q <= READ_UNMAPPED;
		end else if (req.rd) begin
			unique case (req.addr)
				ADDR_VOUT_TWO: rd_data_q <= vout_code_two_q;
				ADDR_STATUS: rd_data_q <= status_q & 8'h19;
				default: rd_data_q <= READ_UNMAPPED;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Ramp timing; the active code walks one step per interval
	function automatic logic [12:0] step_cycles(input logic [1:0] sel);
		unique case (sel)
			2'b00: step_cycles = 13'(RAMP_CYC0);
			2'b01: step_cycles = 13'(RAMP_CYC1);
			2'b10: step_cycles = 13'(RAMP_CYC2);
			default: step_cycles = 13'(RAMP_CYC_SLOW);
		endcase
	endfunction

	assign ramp_tick = ramp_cnt_q == 13'h0001;

	// Step interval counter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ramp_cnt_q <= 13'h0000;
		end else if (ramp_state_q == RAMP_IDLE || ramp_tick) begin
			ramp_cnt_q <= step_cycles(ctl_q[1:0]);
		end else begin
			ramp_cnt_q <= ramp_cnt_q - 13'h0001;
		end
	end

	// Ramp engine: code = 400 mV + 5 mV per count, scaled outside
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ramp_state_q <= RAMP_IDLE;
			vout_active_q <= VOUT_TWO_RST;
		end else begin
			unique case (ramp_state_q)
				RAMP_IDLE: begin
					if (vout_active_q != vout_code_two_q) begin
						ramp_state_q <= RAMP_WAIT;
					end
				end
				RAMP_WAIT: begin
					if (vout_active_q == vout_code_two_q) begin
						ramp_state_q <= RAMP_IDLE;
					end else if (ramp_tick) begin
						ramp_state_q <= RAMP_STEP;
					end
				end
				RAMP_STEP: begin
					if (vout_active_q < vout_code_two_q) begin
						vout_active_q <= vout_active_q + 8'h01;
					end else if (vout_active_q > vout_code_two_q) begin
						vout_active_q <= vout_active_q - 8'h01;
					end
					// No idle hop, so steps stay one interval apart
					ramp_state_q <= RAMP_WAIT;
				end
				default: ramp_state_q <= RAMP_IDLE;
			endcase
		end
	end

	// Forced PWM during a transition when bit 6 is set
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pwm_force_q <= 1'b0;
		end else begin
			pwm_force_q <= ctl_q[CTL_FORCED_PULSE_WIDTH_OPERATION_TRANS_BIT] &
				(ramp_state_q != RAMP_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	a_vout_write: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		wr_commit && req.addr == ADDR_VOUT_TWO && !clear_all |=>
		vout_code_two_q == $past(req.data))
		else $error("vout write lost");
	a_soft_reset: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		soft_reset |=> vout_code_two_q == VOUT_TWO_RST &&
		ctl_q == CONTROL_RST)
		else $error("soft reset failed");
	a_rst_bit_low: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		1'b1 |-> !ctl_q[CTL_RESET_BIT])
		else $error("reset bit stored");
	a_en_fall: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		en_fall |=> vout_code_two_q == VOUT_TWO_RST &&
		ctl_q == CONTROL_RST)
		else $error("enable fall no reset");
	a_no_commit: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		req.wr && !ack_fall && !clear_all |=> $stable(vout_code_two_q))
		else $error("write before ack");
	a_cfg_follow: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		1'b1 |=> cfg_q == $past(ctl_q[4:0]))
		else $error("config does not follow control");
	a_status_read: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		req.rd && req.addr == ADDR_STATUS |=>
		rd_data_q == ($past(status_q) & 8'h19))
		else $error("status read wrong");
	a_status_rsvd: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		req.rd && req.addr == ADDR_STATUS |=> (rd_data_q & 8'hE6) == 8'h00)
		else $error("reserved bits set");
	a_status_clear: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		req.rd && req.addr == ADDR_STATUS && !th_sync_q[1] &&
		!rt_sync_q[1] && !uv_sync_q[1] |=> status_q == STATUS_RST)
		else $error("status not cleared by read");
	a_unmapped_rd: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		req.rd && (req.addr == ADDR_CONTROL || req.addr > ADDR_STATUS) |=>
		rd_data_q == READ_UNMAPPED)
		else $error("unmapped read nonzero");
	a_therm_latch: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		th_sync_q[1] |=> status_q[STS_THERM_BIT])
		else $error("therm lost");
	a_retry_latch: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		rt_sync_q[1] |=> status_q[STS_RETRY_BIT])
		else $error("retry lost");
	a_undervoltage_lockout_flag_latch: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		uv_sync_q[1] |=> status_q[STS_UNDERVOLTAGE_LOCKOUT_FLAG_BIT])
		else $error("undervoltage_lockout_flag lost");
	a_status_hold: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		status_q[STS_RETRY_BIT] && !clear_all && !req.rd |=>
		status_q[STS_RETRY_BIT])
		else $error("retry flag dropped");
	a_pwm_force: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		ctl_q[CTL_FORCED_PULSE_WIDTH_OPERATION_TRANS_BIT] && ramp_state_q == RAMP_WAIT ##1
		ctl_q[CTL_FORCED_PULSE_WIDTH_OPERATION_TRANS_BIT] |-> pwm_force_q)
		else $error("pwm not forced");
	a_pwm_idle: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		!ctl_q[CTL_FORCED_PULSE_WIDTH_OPERATION_TRANS_BIT] |=> !pwm_force_q)
		else $error("pwm forced without bit");
	a_ramp_up: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		ramp_state_q == RAMP_STEP && vout_active_q < vout_code_two_q |=>
		vout_active_q == $past(vout_active_q) + 8'h01)
		else $error("ramp step missing");
	a_ramp_bound: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		ramp_state_q == RAMP_WAIT && ctl_q[1:0] == 2'b00 &&
		ramp_cnt_q == 13'(RAMP_CYC0) |-> ##[1:30] ramp_state_q == RAMP_STEP)
		else $error("fast ramp slow");

	c_vout_write: cover property (@(posedge clk_sys) disable iff (!rstn)
		wr_commit && req.addr == ADDR_VOUT_TWO);
	c_status_read: cover property (@(posedge clk_sys) disable iff (!rstn)
		req.rd && req.addr == ADDR_STATUS && status_q != 8'h00);
	c_soft_reset: cover property (@(posedge clk_sys) disable iff (!rstn)
		soft_reset);
	c_en_fall: cover property (@(posedge clk_sys) disable iff (!rstn)
		en_fall);
	c_ramp_step: cover property (@(posedge clk_sys) disable iff (!rstn)
		ramp_state_q == RAMP_STEP);

endmodule

// ==== test/ctl_model.sv ====
`timescale 1ns/1ps
// Stand-in for the bus controller behind the serial engine
module ctl_model
	import conv_regs_pkg::*;
(
	// Clock and read return
	input wire logic clk_sys,
	input wire logic [7:0] rd_data,
	// Requests
	output reg_req_t req,
	output logic ack_fall
);
	// Idle at time zero
	initial begin
		req = '0;
		ack_fall = 1'b0;
	end

	// One byte write; ack low leaves the byte uncommitted
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic ack);
		@(negedge clk_sys);
		req.wr = 1'b1;
		req.addr = {5'h00, a[2:0]};
		req.data = d;
		ack_fall = ack;
		@(negedge clk_sys);
		req.wr = 1'b0;
		ack_fall = 1'b0;
		// Released data must not echo the byte
		req.data = ~d;
	endtask

	// One byte read, answer taken one cycle on
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		req.rd = 1'b1;
		req.addr = {5'h00, a[2:0]};
		@(negedge clk_sys);
		req.rd = 1'b0;
		d = rd_data;
	endtask
endmodule

// ==== test/tb_buck_converter_i2c_register_bank.sv ====
`timescale 1ns/1ps
module tb_buck_converter_i2c_register_bank;
	import conv_regs_pkg::*;
	// Short slow ramp keeps the run brief
	localparam int SLOW = 20;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic enable_pin = 1'b1;
	logic therm_warn_in = 1'b0;
	logic retry_event_in = 1'b0;
	logic undervoltage_in = 1'b0;
	reg_req_t req;
	logic ack_fall;
	logic [7:0] rd_data_q;
	logic [7:0] vout_code_two_q;
	logic [7:0] vout_active_q;
	conv_cfg_t cfg_q;
	logic pwm_force_q;
	logic restart_q;
	logic [7:0] v;
	int err_total = 0;
	int comparisons = 0;

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	conv_regs #(.RAMP_CYC_SLOW(SLOW)) i_dut (
		.clk_sys(clk_sys), .rstn(rstn), .req(req),
		.ack_fall(ack_fall), .rd_data_q(rd_data_q),
		.enable_pin(enable_pin), .therm_warn_in(therm_warn_in),
		.retry_event_in(retry_event_in),
		.undervoltage_in(undervoltage_in), .cfg_q(cfg_q),
		.vout_code_two_q(vout_code_two_q),
		.vout_active_q(vout_active_q),
		.pwm_force_q(pwm_force_q), .restart_q(restart_q)
	);
	ctl_model i_ctl (
		.clk_sys(clk_sys), .rd_data(rd_data_q),
		.req(req), .ack_fall(ack_fall)
	);

	////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("errors %0d checks %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Reset values and address decode
	task automatic t_defaults();
		check("vout", vout_code_two_q, VOUT_TWO_RST);
		i_ctl.rd(ADDR_VOUT_TWO, v);
		check("rd vout", v, 8'h64);
		check("cfg", {3'h0, cfg_q}, 8'h0F);
		i_ctl.rd(ADDR_CONTROL, v);
		check("rd ctl", v, 8'h00);
		for (int a = 0; a < 8; a++) begin
			if (!(a inside {1, 2, 3, 5})) begin
				i_ctl.rd(a[7:0], v);
				check("unmapped", v, 8'h00);
			end
		end
	endtask

	// Code extremes, a byte never acknowledged, a read-only target
	task automatic t_vout();
		i_ctl.wr(ADDR_VOUT_TWO, 8'hFF, 1'b1);
		check("vout max", vout_code_two_q, 8'hFF);
		i_ctl.wr(ADDR_VOUT_TWO, 8'h00, 1'b1);
		i_ctl.rd(ADDR_VOUT_TWO, v);
		check("vout min", v, 8'h00);
		i_ctl.wr(ADDR_VOUT_TWO, 8'h5A, 1'b0);
		check("no ack", vout_code_two_q, 8'h00);
		i_ctl.wr(ADDR_STATUS, 8'hFF, 1'b1);
		i_ctl.rd(ADDR_STATUS, v);
		check("sts wr", v, 8'h00);
	endtask

	// Every ramp code, mode bits toggled alongside
	task automatic t_ctrl();
		for (int i = 0; i < 4; i++) begin
			v = {3'h0, i[0], ~i[0], i[1], i[1:0]};
			i_ctl.wr(ADDR_CONTROL, v, 1'b1);
			wait_cyc(1);
			check("cfg", {3'h0, cfg_q}, v);
		end
	endtask

	// Short event pulses must stay latched until read
	task automatic t_status();
		therm_warn_in = 1'b1;
		retry_event_in = 1'b1;
		undervoltage_in = 1'b1;
		wait_cyc(5);
		therm_warn_in = 1'b0;
		retry_event_in = 1'b0;
		undervoltage_in = 1'b0;
		wait_cyc(5);
		i_ctl.rd(ADDR_STATUS, v);
		check("sts", v, 8'h19);
		i_ctl.rd(ADDR_STATUS, v);
		check("sts clr", v, 8'h00);
	endtask

	// Soft reset bit, then an enable falling edge
	task automatic t_resets();
		i_ctl.wr(ADDR_VOUT_TWO, 8'h20, 1'b1);
		i_ctl.wr(ADDR_CONTROL, 8'h10, 1'b1);
		i_ctl.wr(ADDR_CONTROL, 8'h80, 1'b1);
		check("restart on", {7'h0, restart_q}, 8'h01);
		wait_cyc(3);
		check("restart off", {7'h0, restart_q}, 8'h00);
		check("soft vout", vout_code_two_q, 8'h64);
		check("soft cfg", {3'h0, cfg_q}, 8'h0F);
		i_ctl.wr(ADDR_VOUT_TWO, 8'h30, 1'b1);
		i_ctl.wr(ADDR_CONTROL, 8'h10, 1'b1);
		enable_pin = 1'b0;
		wait_cyc(6);
		check("en vout", vout_code_two_q, 8'h64);
		check("en cfg", {3'h0, cfg_q}, 8'h0F);
		enable_pin = 1'b1;
		wait_cyc(4);
	endtask

	// Two fast steps with forced PWM during the change
	task automatic t_ramp();
		int n = 0;
		while (vout_active_q !== vout_code_two_q && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		check("settle", {7'h0, n < 20000}, 8'h01);
		i_ctl.wr(ADDR_CONTROL, 8'h40, 1'b1);
		i_ctl.wr(ADDR_VOUT_TWO, 8'h66, 1'b1);
		n = 0;
		while (vout_active_q !== 8'h66 && n < 200) begin
			@(negedge clk_sys);
			n++;
			if (n == 10) check("pwm on", {7'h0, pwm_force_q}, 8'h01);
		end
		check("ramp", {7'h0, n >= 48 && n <= 60}, 8'h01);
		wait_cyc(3);
		check("pwm off", {7'h0, pwm_force_q}, 8'h00);
	endtask

	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		wait_cyc(5);
		rstn = 1'b1;
		wait_cyc(1);
		t_defaults();
		t_vout();
		t_ctrl();
		t_status();
		t_resets();
		t_ramp();
		test_done();
	end

	// Watchdog well past the slowest ramp settle
	initial begin
		#300000;
		err_total++;
		test_done();
	end
endmodule
